// [hw/cbs_pkg.sv]
package cbs_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_WREG = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_IO_BASE = 8'h20;
  localparam int IO_N = 8;
  localparam int IO_IDX_W = 3;
  // Command word fields
  localparam int OP_W = 5;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_K_LSB = 16;
  localparam int CMD_IDX_LSB = 24;
  localparam int K_W = 7;
  // Status word fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  // Status register flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  // Reset values and program counter step
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] IO_RST = 8'h00;
  localparam logic [15:0] PC_STEP = 16'h0001;
  // Operation codes
  typedef enum logic [4:0] {
    CBS_BRANCH_CARRY_CLEAR = 5'h00,
    CBS_BRANCH_LOWER = 5'h01,
    CBS_BRANCH_NEGATIVE = 5'h02,
    CBS_BRANCH_POSITIVE = 5'h03,
    CBS_BRANCH_SIGNED_GE = 5'h04,
    CBS_BRANCH_SIGNED_LT = 5'h05,
    CBS_BRANCH_HALFCARRY_SET = 5'h06,
    CBS_BRANCH_HALFCARRY_CLEAR = 5'h07,
    CBS_BRANCH_TRANSFER_BIT_SET = 5'h08,
    CBS_BRANCH_IRQ_ENABLED = 5'h09,
    CBS_BRANCH_IRQ_DISABLED = 5'h0A,
    CBS_SET_IO_BIT = 5'h0B,
    CBS_CLEAR_IO_BIT = 5'h0C,
    CBS_LOGICAL_LEFT_SHIFT = 5'h0D,
    CBS_LOGICAL_RIGHT_SHIFT = 5'h0E,
    CBS_ROTATE_LEFT_CARRY = 5'h0F,
    CBS_ROTATE_RIGHT_CARRY = 5'h10,
    CBS_ARITH_RIGHT_SHIFT = 5'h11,
    CBS_NIBBLE_SWAP = 5'h12,
    CBS_FLAG_SET_OP = 5'h13,
    CBS_FLAG_CLEAR_OP = 5'h14
  } cbs_op_t;
  // Alias sharing the carry-clear encoding
  localparam cbs_op_t CBS_BRANCH_SAME_OR_HIGHER = CBS_BRANCH_CARRY_CLEAR;
  // Sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RUN = 2'b01,
    S_WAIT = 2'b10
  } cbs_state_t;
endpackage

// [hw/cbs_exec.sv]
`timescale 1ns/1ps
module cbs_exec
  import cbs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  logic rst_s1_q;
  logic rst_n_q;
  cbs_state_t st_q;
  cbs_op_t op_q;
  logic [2:0] bit_q;
  logic [K_W-1:0] k_q;
  logic [IO_IDX_W-1:0] idx_q;
  logic [7:0] flg_q;
  logic [15:0] pc_q;
  logic [7:0] wreg_q;
  logic [7:0] io_q [IO_N];
  logic taken_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic busy;
  logic access;
  logic wr_ok;
  logic take;
  logic is_br;
  logic is_io;
  logic is_sh;
  logic two;
  logic commit;
  logic [7:0] sh_res;
  logic sh_c;
  logic [7:0] flg_d;
  logic [15:0] tgt;
  // Branch condition per operation code
  function automatic logic br_cond(input cbs_op_t op, input logic [7:0] f);
    case (op)
      CBS_BRANCH_CARRY_CLEAR: br_cond = !f[FLG_C];
      CBS_BRANCH_LOWER: br_cond = f[FLG_C];
      CBS_BRANCH_NEGATIVE: br_cond = f[FLG_N];
      CBS_BRANCH_POSITIVE: br_cond = !f[FLG_N];
      CBS_BRANCH_SIGNED_GE: br_cond = !(f[FLG_N] ^ f[FLG_V]);
      CBS_BRANCH_SIGNED_LT: br_cond = f[FLG_N] ^ f[FLG_V];
      CBS_BRANCH_HALFCARRY_SET: br_cond = f[FLG_H];
      CBS_BRANCH_HALFCARRY_CLEAR: br_cond = !f[FLG_H];
      CBS_BRANCH_TRANSFER_BIT_SET: br_cond = f[FLG_T];
      CBS_BRANCH_IRQ_ENABLED: br_cond = f[FLG_I];
      CBS_BRANCH_IRQ_DISABLED: br_cond = !f[FLG_I];
      default: br_cond = 1'b0;
    endcase
  endfunction

  // Address decode of the I/O window, used by the APB answer only, for read data and the error flag
  function automatic logic addr_is_io(input logic [7:0] a);
    addr_is_io = (a >= ADDR_IO_BASE) && (a < ADDR_IO_BASE + 8'(IO_N * 4)) && (a[1:0] == 2'b00);
  endfunction

  // Reset release synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // APB access qualifiers; writes are ignored while an operation runs
  assign busy = (st_q != S_IDLE);
  assign access = psel && penable && pready_q;
  assign wr_ok = access && pwrite && !busy && !pslverr_q;

  // Operation decode and result datapath
  always_comb begin
    take = br_cond(op_q, flg_q);
    is_br = (op_q <= CBS_BRANCH_IRQ_DISABLED);
    is_io = (op_q == CBS_SET_IO_BIT) || (op_q == CBS_CLEAR_IO_BIT);
    is_sh = (op_q >= CBS_LOGICAL_LEFT_SHIFT) && (op_q <= CBS_ARITH_RIGHT_SHIFT);
    two = (is_br && take) || is_io;
    commit = ((st_q == S_RUN) && !two) || (st_q == S_WAIT);
    tgt = pc_q + {{(16-K_W){k_q[K_W-1]}}, k_q} + PC_STEP;
    sh_res = wreg_q;
    sh_c = flg_q[FLG_C];
    case (op_q)
      CBS_LOGICAL_LEFT_SHIFT: begin
        sh_res = {wreg_q[6:0], 1'b0};
        sh_c = wreg_q[7];
      end
      CBS_LOGICAL_RIGHT_SHIFT: begin
        sh_res = {1'b0, wreg_q[7:1]};
        sh_c = wreg_q[0];
      end
      CBS_ROTATE_LEFT_CARRY: begin
        sh_res = {wreg_q[6:0], flg_q[FLG_C]};
        sh_c = wreg_q[7];
      end
      CBS_ROTATE_RIGHT_CARRY: begin
        sh_res = {flg_q[FLG_C], wreg_q[7:1]};
        sh_c = wreg_q[0];
      end
      CBS_ARITH_RIGHT_SHIFT: begin
        sh_res = {wreg_q[7], wreg_q[7:1]};
        sh_c = wreg_q[0];
      end
      CBS_NIBBLE_SWAP: sh_res = {wreg_q[3:0], wreg_q[7:4]};
      default: ;
    endcase
    flg_d = flg_q;
    if (is_sh) begin
      flg_d[FLG_Z] = (sh_res == 8'h00);
      flg_d[FLG_C] = sh_c;
      flg_d[FLG_N] = sh_res[7];
      flg_d[FLG_V] = sh_res[7] ^ sh_c;
    end
    if (op_q == CBS_FLAG_SET_OP || op_q == CBS_FLAG_CLEAR_OP) begin
      flg_d[bit_q] = (op_q == CBS_FLAG_SET_OP);
    end
  end

  // Sequencer: one cycle, or two for taken branches and io bit ops
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= S_IDLE;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (wr_ok && paddr == ADDR_CMD) begin
            st_q <= S_RUN;
          end
        end
        S_RUN: st_q <= two ? S_WAIT : S_IDLE;
        S_WAIT: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Command latch
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      op_q <= CBS_NIBBLE_SWAP;
      bit_q <= 3'h0;
      k_q <= 7'h00;
      idx_q <= 3'h0;
    end else if (wr_ok && paddr == ADDR_CMD) begin
      op_q <= cbs_op_t'(pwdata[CMD_OP_LSB +: OP_W]);
      bit_q <= pwdata[CMD_BIT_LSB +: 3];
      k_q <= pwdata[CMD_K_LSB +: K_W];
      idx_q <= pwdata[CMD_IDX_LSB +: IO_IDX_W];
    end
  end
  // Status register; branches, io ops and swap leave it alone
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flg_q <= FLAGS_RST;
    end else if (wr_ok && paddr == ADDR_FLAGS) begin
      flg_q <= pwdata[7:0];
    end else if (commit) begin
      flg_q <= flg_d;
    end
  end

  // Program counter
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pc_q <= PC_RST;
    end else if (wr_ok && paddr == ADDR_PC) begin
      pc_q <= pwdata[15:0];
    end else if (commit) begin
      pc_q <= (is_br && take) ? tgt : pc_q + PC_STEP;
    end
  end

  // Working register and whether the last operation was a taken branch
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wreg_q <= WREG_RST;
      taken_q <= 1'b0;
    end else begin
      if (wr_ok && paddr == ADDR_WREG) begin
        wreg_q <= pwdata[7:0];
      end else if (commit) begin
        wreg_q <= sh_res;
      end
      if (commit) begin
        taken_q <= is_br && take;
      end
    end
  end

  // I/O registers with bit set and clear
  for (genvar g = 0; g < IO_N; g++) begin : g_io
    always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        io_q[g] <= IO_RST;
      end else if (wr_ok && paddr == ADDR_IO_BASE + 8'(g * 4)) begin
        io_q[g] <= pwdata[7:0];
      end else if (commit && is_io && idx_q == IO_IDX_W'(g)) begin
        io_q[g][bit_q] <= (op_q == CBS_SET_IO_BIT);
      end
    end
  end

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      case (paddr)
        ADDR_CMD: begin
          prdata_q[CMD_OP_LSB +: OP_W] <= op_q;
          prdata_q[CMD_BIT_LSB +: 3] <= bit_q;
          prdata_q[CMD_K_LSB +: K_W] <= k_q;
          prdata_q[CMD_IDX_LSB +: IO_IDX_W] <= idx_q;
        end
        ADDR_FLAGS: prdata_q[7:0] <= flg_q;
        ADDR_PC: prdata_q[15:0] <= pc_q;
        ADDR_WREG: prdata_q[7:0] <= wreg_q;
        ADDR_STAT: begin
          prdata_q[STAT_BUSY] <= busy;
          prdata_q[STAT_TAKEN] <= taken_q;
        end
        default: begin
          if (addr_is_io(paddr)) begin
            prdata_q[7:0] <= io_q[paddr[IO_IDX_W+1:2]];
          end else begin
            pslverr_q <= 1'b1;
          end
        end
      endcase
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // Checks
  property p_br_target;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && is_br && take) |-> ##2 (pc_q == $past(tgt, 2));
  endproperty
  a_br_target: assert property (p_br_target) else $error("taken branch target wrong");
  property p_br_not_taken;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && is_br && !take) |=> (st_q == S_IDLE) && (pc_q == $past(pc_q) + PC_STEP);
  endproperty
  a_br_not_taken: assert property (p_br_not_taken) else $error("untaken branch wrong");
  property p_br_carry;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && op_q == CBS_BRANCH_LOWER) |=>
      ((st_q == S_WAIT) == $past(flg_q[FLG_C])) && $stable(flg_q);
  endproperty
  a_br_carry: assert property (p_br_carry) else $error("lower branch condition wrong");
  property p_br_flags;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && is_br && take) |=> (st_q == S_WAIT) ##1 (st_q == S_IDLE && $stable(flg_q));
  endproperty
  a_br_flags: assert property (p_br_flags) else $error("taken branch timing or flags wrong");
  property p_br_signed;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && op_q == CBS_BRANCH_SIGNED_LT) |=>
      ((st_q == S_WAIT) == $past(flg_q[FLG_N] ^ flg_q[FLG_V]));
  endproperty
  a_br_signed: assert property (p_br_signed) else $error("signed branch wrong");
  property p_io_set;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && op_q == CBS_SET_IO_BIT) |=> (st_q == S_WAIT) ##1
      (io_q[idx_q][bit_q] == 1'b1 && flg_q == $past(flg_q, 2));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_left_shift;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && op_q == CBS_LOGICAL_LEFT_SHIFT) |=>
      (wreg_q == {$past(wreg_q[6:0]), 1'b0}) && (flg_q[FLG_C] == $past(wreg_q[7]));
  endproperty
  a_left_shift: assert property (p_left_shift) else $error("left shift wrong");
  property p_rotate_right;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && op_q == CBS_ROTATE_RIGHT_CARRY) |=>
      (wreg_q == {$past(flg_q[FLG_C]), $past(wreg_q[7:1])}) && (flg_q[FLG_C] == $past(wreg_q[0]));
  endproperty
  a_rotate_right: assert property (p_rotate_right) else $error("rotate right wrong");
  property p_swap;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && op_q == CBS_NIBBLE_SWAP) |=>
      (wreg_q == {$past(wreg_q[3:0]), $past(wreg_q[7:4])}) && $stable(flg_q) && (st_q == S_IDLE);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");
  property p_flag_set;
    @(posedge sys_clk) disable iff (!rst_n_q)
    (st_q == S_RUN && op_q == CBS_FLAG_SET_OP) |=> (flg_q[$past(bit_q)] == 1'b1);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
endmodule // cbs_exec

// [verif/cbs_exec_bench.sv]
`timescale 1ns/1ps
module cbs_exec_bench;
  import cbs_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cbs_exp_t;
  logic sys_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cbs_exp_t exq[$];
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;

  cbs_exec u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      summarize();
    end
  end

  // One APB transfer; the expectation is queued for the monitor
  task automatic xact(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
    begin
      exq.push_back('{d: (w ? 32'h0 : d), m: (w ? 32'h0 : m), e: e});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge
      do begin
        @(posedge sys_clk);
      end while (pready !== 1'b1);
    end
  endtask

  // Bus released for a number of cycles
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  // Monitor: compares each completed transfer with the oldest note
  always @(posedge sys_clk) begin
    cbs_exp_t x;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      x = exq.pop_front();
      checks++;
      if ((prdata & x.m) !== (x.d & x.m) || pslverr !== x.e) begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time,
                 {pslverr, prdata & x.m}, {x.e, x.d & x.m});
      end
    end
  end

  // Reference behaviour of one operation
  task automatic model(input logic [4:0] op, input logic [7:0] s, input logic [7:0] w,
                       input logic [7:0] io, input logic [15:0] pc, input logic [2:0] b,
                       input logic [6:0] k, output logic [7:0] so, output logic [7:0] wo,
                       output logic [7:0] ioo, output logic [15:0] pco, output logic tk);
    logic c;
    logic [7:0] r;
    begin
      so = s;
      wo = w;
      ioo = io;
      tk = 1'b0;
      c = s[FLG_C];
      r = w;
      case (op)
        5'h00: tk = !s[FLG_C];
        5'h01: tk = s[FLG_C];
        5'h02: tk = s[FLG_N];
        5'h03: tk = !s[FLG_N];
        5'h04: tk = !(s[FLG_N] ^ s[FLG_V]);
        5'h05: tk = s[FLG_N] ^ s[FLG_V];
        5'h06: tk = s[FLG_H];
        5'h07: tk = !s[FLG_H];
        5'h08: tk = s[FLG_T];
        5'h09: tk = s[FLG_I];
        5'h0A: tk = !s[FLG_I];
        5'h0B: ioo[b] = 1'b1;
        5'h0C: ioo[b] = 1'b0;
        5'h0D: {c, r} = {w, 1'b0};
        5'h0E: {r, c} = {1'b0, w};
        5'h0F: {c, r} = {w, s[FLG_C]};
        5'h10: {r, c} = {s[FLG_C], w};
        5'h11: {r, c} = {w[7], w};
        5'h12: wo = {w[3:0], w[7:4]};
        5'h13: so[b] = 1'b1;
        5'h14: so[b] = 1'b0;
        default: ;
      endcase
      if (op inside {[5'h0D:5'h11]}) begin
        wo = r;
        so[FLG_C] = c;
        so[FLG_Z] = (r == 8'h00);
        so[FLG_N] = r[7];
        so[FLG_V] = r[7] ^ c;
      end
      pco = pc + (tk ? {{9{k[6]}}, k} + PC_STEP : PC_STEP);
    end
  endtask

  // Loads random state, issues one command and reads every result back
  task automatic run(input logic [4:0] op);
    logic [7:0] s, w, io, so, wo, ioo, ia;
    logic [15:0] pc, pco;
    logic [2:0] b, idx;
    logic [6:0] k;
    logic tk;
    begin
      s = 8'($urandom());
      w = 8'($urandom());
      io = 8'($urandom());
      pc = 16'($urandom());
      b = 3'($urandom());
      idx = 3'($urandom());
      k = 7'($urandom());
      ia = ADDR_IO_BASE + 8'({idx, 2'b00});
      model(op, s, w, io, pc, b, k, so, wo, ioo, pco, tk);
      xact(1'b1, ADDR_FLAGS, {24'h0, s}, 32'h0, 1'b0);
      xact(1'b1, ADDR_PC, {16'h0, pc}, 32'h0, 1'b0);
      xact(1'b1, ADDR_WREG, {24'h0, w}, 32'h0, 1'b0);
      xact(1'b1, ia, {24'h0, io}, 32'h0, 1'b0);
      xact(1'b1, ADDR_CMD, {5'h0, idx, 1'b0, k, 5'h0, b, 3'h0, op}, 32'h0, 1'b0);
      // Busy is still seen by a read right behind the command only for two-cycle work
      xact(1'b0, ADDR_STAT, {31'h0, (tk || (op inside {5'h0B, 5'h0C}))}, 32'h1, 1'b0);
      idle(2);
      xact(1'b0, ADDR_FLAGS, {24'h0, so}, '1, 1'b0);
      xact(1'b0, ADDR_PC, {16'h0, pco}, '1, 1'b0);
      xact(1'b0, ADDR_WREG, {24'h0, wo}, '1, 1'b0);
      xact(1'b0, ia, {24'h0, ioo}, '1, 1'b0);
      xact(1'b0, ADDR_STAT, {30'h0, tk, 1'b0}, 32'h3, 1'b0);
      idle(1);
    end
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'hA9EC));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Reset contents and bus errors
    xact(1'b0, ADDR_CMD, 32'h12, '1, 1'b0);
    xact(1'b0, ADDR_PC, 32'h0, '1, 1'b0);
    xact(1'b0, ADDR_FLAGS, 32'h0, '1, 1'b0);
    xact(1'b1, ADDR_STAT, 32'h3, 32'h0, 1'b0);
    xact(1'b0, ADDR_STAT, 32'h0, '1, 1'b0);
    xact(1'b1, 8'h44, 32'h5A, 32'h0, 1'b1);
    xact(1'b0, 8'h40, 32'h0, '1, 1'b1);
    idle(1);
    // Every opcode, including one unknown code, with random operands
    for (int i = 0; i < 88; i++) begin
      run(5'(i % 22));
    end
    idle(2);
    summarize();
  end
endmodule // cbs_exec_bench
